/* design/dio_monoflop.sv */
/*
 debounce monoflop for one synchronised pin input.
 assumes its input is already in the system clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module dio_monoflop
	import dio_pkg::*;
#(
	parameter logic [DEB_CNT_W-1:0] p_hold_cyc = DEB_CNT_W'(DEBOUNCE_CYC)
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_en,
	input wire logic i_level,
	output logic o_level
);
	typedef enum logic [0:0] {
		MF_IDLE = 1'b0,
		MF_HOLD = 1'b1
	} dio_mf_state_type;
	typedef struct packed {
		dio_mf_state_type st;
		logic lvl;
		logic [DEB_CNT_W-1:0] cnt;
	} dio_mf_type;
	dio_mf_type st_ff;
	dio_mf_type nxt_st;

	always_comb begin
		nxt_st = st_ff;
		case (st_ff.st)
			MF_IDLE: begin
				if (i_level != st_ff.lvl) begin
					nxt_st.lvl = i_level;
					// further transitions are ignored for the window
					if (i_en) begin
						nxt_st.st = MF_HOLD;
						nxt_st.cnt = p_hold_cyc;
					end
				end
			end
			MF_HOLD: begin
				if (st_ff.cnt <= DEB_CNT_W'(1) || !i_en) begin
					nxt_st.st = MF_IDLE;
				end
				nxt_st.cnt = st_ff.cnt - DEB_CNT_W'(1);
			end
			default: nxt_st.st = MF_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st_ff <= '{st: MF_IDLE, lvl: 1'b0, cnt: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_level = st_ff.lvl;
endmodule
`default_nettype wire

/* design/dio_pkg.sv */
/*
 bit numbers, timing counts, reset values and carrier types of the processor
 condition-bit and strobe-bit interface.
 assumes one 100 MHz system clock and a synchronous active-high reset.
*/
package dio_pkg;
	// ------------------------------------------------------------
	// write bit positions
	// ------------------------------------------------------------
	localparam int unsigned WB_BANDGAP = 15;
	localparam int unsigned WB_LOWBAT = 14;
	localparam int unsigned WB_EE_ERASE = 13;
	localparam int unsigned WB_EE_READ = 12;
	localparam int unsigned WB_IRQ = 11;
	localparam int unsigned WB_RESERVED = 10;
	localparam int unsigned WB_RES_START = 9;
	localparam int unsigned WB_CAP_START = 8;
	localparam int unsigned WB_WDOG = 7;
	localparam int unsigned WB_INIT = 6;
	localparam int unsigned WB_PIN_FIVE = 5;
	localparam int unsigned WB_PIN_FOUR = 4;
	// ------------------------------------------------------------
	// read bit positions
	// ------------------------------------------------------------
	localparam int unsigned RB_LVL_FEEDBACK = 56;
	localparam int unsigned RB_PIN_TRIG_N = 53;
	localparam int unsigned RB_OFL_N = 47;
	localparam int unsigned RB_OFL = 46;
	localparam int unsigned RB_CAR_N = 45;
	localparam int unsigned RB_CAR = 44;
	localparam int unsigned RB_EQ = 43;
	localparam int unsigned RB_NE = 42;
	localparam int unsigned RB_POS = 41;
	localparam int unsigned RB_CAP_ERR_N = 11;
	localparam int unsigned RB_COMB_ERR_N = 10;
	localparam int unsigned RB_FE_ACTIVE_N = 9;
	localparam int unsigned RB_LOWBAT_BUSY = 8;
	localparam int unsigned RB_EEPROM_BUSY = 7;
	localparam int unsigned RB_IRQ_PIN = 6;
	localparam int unsigned RB_TEMP_ERR_N = 5;
	localparam int unsigned RB_RES_BUSY = 4;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned DEBOUNCE_MS = 40;
	localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_MS * 1000000) / CLK_PERIOD_NS;
	localparam int unsigned DEB_CNT_W = 22;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] LVL_RST = 8'h00;
	localparam logic IRQ_N_RST = 1'b1;
	localparam logic [3:0] FLAGS_RST = 4'h0;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ALU_ADD = 2'b00,
		ALU_SUB = 2'b01,
		ALU_MULDIV = 2'b10,
		ALU_MOVE = 2'b11
	} dio_alu_op_type;
	typedef struct packed {
		logic valid;
		dio_alu_op_type op;
		logic [47:0] a;
		logic [47:0] b;
		logic [47:0] result;
		logic ofl;
		logic car;
	} dio_alu_req_type;
	typedef struct packed {
		logic ofl;
		logic car;
		logic eq;
		logic pos;
	} dio_flags_type;
	typedef struct packed {
		logic valid;
		logic set;
		logic [3:0] idx;
	} dio_bit_wr_type;
	typedef struct packed {
		logic cap_error_flag_n;
		logic combined_error_flag_n;
		logic frontend_active_n;
		logic low_battery_busy;
		logic eeprom_busy;
		logic temp_error_n;
		logic resistance_busy;
	} dio_status_type;
	typedef struct packed {
		logic bandgap_start_pulse;
		logic low_battery_start_pulse;
		logic eeprom_erase_strobe;
		logic eeprom_read_strobe;
		logic resistance_start_pulse;
		logic capacitance_start_pulse;
		logic watchdog_restart;
		logic init_reset;
	} dio_strobe_type;
	typedef struct packed {
		logic spi_mode;
		logic pulse_zero_on_two;
		logic pulse_one_on_three;
		logic irq_on_pin_two;
		logic [3:0] dir_in;
		logic [3:0] pull_up;
		logic [3:0] latch_mask;
		logic [3:0] debounce_en;
		logic [1:0] start_pin_sel;
		logic [1:0] pulse_gen_on;
	} dio_cfg_type;
endpackage

/* design/dio_top.sv */
/*
 condition-bit and strobe-bit interface of the embedded 48-bit processor:
 output bits, input bits, alu flags, pin routing, trigger latches, debounce.
 assumes the processor core, measurement units and serial host share i_clk_sys;
 pins 0 to 3 are asynchronous and are synchronised here.
*/
// Functional notes
// - write bit 9 pulses resistance start, bit 8 capacitance start, self clearing
// - write bit 15 pulses bandgap start, bit 14 low battery start
// - write bit 13 pulses eeprom erase strobe, bit 12 eeprom read strobe
// - write bit 11 asserts interrupt pin low until released
// - read bit 6 shows interrupt pin; slave select rise or stop releases it
// - read bit 11 capacitance error low, bit 10 combined error low
// - read bit 9 low while capacitance front end active
// - read bit 8 low battery busy, bit 7 eeprom busy
// - read bit 5 zero on temperature error, one otherwise
// - write bit 7 restarts watchdog, bit 6 requests initialisation reset
// - write bits 5 and 4 drive output only pins five and four
// - bits 3 and 2 drive pins three and two while pulse generator off
// - bits 1 and 0 set or sample pins zero and one, readable
// - rising edge of selected trigger latch starts processor; status held until stop
// - alu updates overflow, carry, equal, sign; overflow outside 48-bit signed range
// - addition carry only on carry out of most significant bit
// - subtraction carry one unless minuend below subtrahend
// - pin roles: slave select, miso, bits, triggers, pulses, interrupt on two
// - input pins have selectable debounce and pull-up
// - debounce suppresses further transitions for fixed window after an edge
// - flags and complements readable as condition bits 41 to 47
// - eight output bits 0 to 7 individually set and cleared by bit instructions
`timescale 1ns/100ps
`default_nettype none
module dio_top
	import dio_pkg::*;
#(
	parameter logic [DEB_CNT_W-1:0] p_debounce_cyc = DEB_CNT_W'(DEBOUNCE_CYC)
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_dsp_stop,
	input wire dio_bit_wr_type i_bit_wr,
	input wire dio_alu_req_type i_alu,
	input wire dio_status_type i_status,
	input wire dio_cfg_type i_cfg,
	input wire logic [1:0] i_pulse_gen,
	input wire logic i_spi_miso,
	input wire logic i_i2c_stop,
	input wire logic [3:0] i_pin,
	output logic [3:0] o_pin,
	output logic [3:0] o_pin_oe,
	output logic [3:0] o_pin_pullup,
	output logic o_pin_four,
	output logic o_pin_five,
	output logic o_irq_pin_n,
	output logic o_spi_ssn,
	output logic o_dsp_start,
	output logic [3:0] o_trigger_latch,
	output dio_strobe_type o_strobe,
	output dio_flags_type o_flags,
	output logic [63:0] o_cond
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] filt_q;
		logic [3:0] latch;
		logic [1:0] sel_q;
		logic ssn_q;
		logic [1:0] warm;
		logic irq_n;
		logic pin_trig;
		logic start;
		logic [7:0] lvl;
		dio_strobe_type strobe;
		dio_flags_type flags;
		logic [3:0] pin_o;
		logic [3:0] pin_oe;
		logic [3:0] pull;
		logic [63:0] cond;
	} dio_state_type;
	dio_state_type st_ff;
	dio_state_type nxt_st;
	logic [3:0] filt;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic wr_hit(input dio_bit_wr_type w, input int unsigned idx,
		input logic set);
		wr_hit = w.valid && (w.idx == 4'(idx)) && (w.set == set);
	endfunction

	function automatic dio_flags_type alu_flags(input dio_alu_req_type r,
		input dio_flags_type old);
		logic [48:0] sum;
		logic [47:0] res;
		dio_flags_type f;
		sum = '0;
		res = r.result;
		f = old;
		case (r.op)
			ALU_ADD: begin
				sum = {1'b0, r.a} + {1'b0, r.b};
				res = sum[47:0];
				f.car = sum[48];
				f.ofl = (r.a[47] == r.b[47]) && (res[47] != r.a[47]);
			end
			ALU_SUB: begin
				sum = {1'b0, r.a} + {1'b0, ~r.b} + 49'h0_0000_0000_0001;
				res = sum[47:0];
				f.car = sum[48];
				f.ofl = (r.a[47] != r.b[47]) && (res[47] != r.a[47]);
			end
			ALU_MULDIV: begin
				f.car = r.car;
				f.ofl = r.ofl;
			end
			default: begin
				f.car = old.car;
				f.ofl = old.ofl;
			end
		endcase
		f.eq = (res == 48'h0000_0000_0000);
		f.pos = ~res[47];
		alu_flags = f;
	endfunction

	// ------------------------------------------------------------
	// debounce per bidirectional pin
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_deb
			dio_monoflop #(
				.p_hold_cyc(p_debounce_cyc)
			) u_mf (
				.i_clk_sys(i_clk_sys),
				.i_sys_rst(i_sys_rst),
				.i_en(i_cfg.debounce_en[gi]),
				.i_level(st_ff.sync2[gi]),
				.o_level(filt[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic ssn_rise;
		logic irq_clr;
		logic [3:0] rise;
		logic [3:0] drv;
		logic [3:0] rd;
		logic [1:0] pg;
		nxt_st = st_ff;
		ssn_rise = 1'b0;
		irq_clr = 1'b0;
		rise = 4'h0;
		drv = 4'h0;
		rd = 4'h0;
		pg = 2'b00;

		// pins pass two flip-flops before use
		nxt_st.sync1 = i_pin;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.filt_q = filt;
		nxt_st.ssn_q = st_ff.sync2[0];

		// level bits 0 to 7, set and clear by bit instructions
		for (int i = 0; i < 8; i++) begin
			if (wr_hit(i_bit_wr, i, 1'b1)) begin
				nxt_st.lvl[i] = 1'b1;
			end else if (wr_hit(i_bit_wr, i, 1'b0)) begin
				nxt_st.lvl[i] = 1'b0;
			end
		end

		// self clearing strobes for bits 8, 9 and 12 to 15, bits 7 and 6 follow their level; bit 10 has no effect
		nxt_st.strobe.bandgap_start_pulse = wr_hit(i_bit_wr, WB_BANDGAP, 1'b1);
		nxt_st.strobe.low_battery_start_pulse = wr_hit(i_bit_wr, WB_LOWBAT, 1'b1);
		nxt_st.strobe.eeprom_erase_strobe = wr_hit(i_bit_wr, WB_EE_ERASE, 1'b1);
		nxt_st.strobe.eeprom_read_strobe = wr_hit(i_bit_wr, WB_EE_READ, 1'b1);
		nxt_st.strobe.resistance_start_pulse = wr_hit(i_bit_wr, WB_RES_START, 1'b1);
		nxt_st.strobe.capacitance_start_pulse = wr_hit(i_bit_wr, WB_CAP_START, 1'b1);
		nxt_st.strobe.watchdog_restart = nxt_st.lvl[WB_WDOG];
		nxt_st.strobe.init_reset = nxt_st.lvl[WB_INIT];

		// interrupt pin: set wins over release; edge detect waits for primed synchroniser
		if (st_ff.warm != 2'h3) begin
			nxt_st.warm = st_ff.warm + 2'h1;
		end
		ssn_rise = i_cfg.spi_mode && (st_ff.warm == 2'h3) && st_ff.sync2[0] && !st_ff.ssn_q;
		irq_clr = ssn_rise || i_i2c_stop;
		if (wr_hit(i_bit_wr, WB_IRQ, 1'b1)) begin
			nxt_st.irq_n = 1'b0;
		end else if (irq_clr) begin
			nxt_st.irq_n = 1'b1;
		end

		// trigger latches, released by setting the matching bit
		rise = filt & ~st_ff.filt_q & i_cfg.dir_in;
		for (int i = 0; i < 4; i++) begin
			if (rise[i] && i_cfg.latch_mask[i]) begin
				nxt_st.latch[i] = 1'b1;
			end else if (st_ff.lvl[i]) begin
				nxt_st.latch[i] = 1'b0;
			end
		end

		// processor start on rising edge of the selected latch
		nxt_st.sel_q = {1'b0, st_ff.latch[i_cfg.start_pin_sel]};
		nxt_st.start = st_ff.latch[i_cfg.start_pin_sel] && !st_ff.sel_q[0];
		if (st_ff.start) begin
			nxt_st.pin_trig = 1'b1;
		end else if (i_dsp_stop) begin
			nxt_st.pin_trig = 1'b0;
		end

		// alu flags
		if (i_alu.valid) begin
			nxt_st.flags = alu_flags(i_alu, st_ff.flags);
		end

		// pin routing: bits drive pins, pulses or ored in while bit held clear
		pg = i_cfg.pulse_gen_on & i_pulse_gen;
		drv = nxt_st.lvl[3:0];
		drv[2] = nxt_st.lvl[2] | (pg[0] & i_cfg.pulse_zero_on_two);
		drv[3] = nxt_st.lvl[3] | (pg[1] & i_cfg.pulse_one_on_three);
		if (i_cfg.pulse_gen_on[0] && !i_cfg.pulse_zero_on_two) begin
			drv[0] = pg[0];
		end
		if (i_cfg.pulse_gen_on[1] && !i_cfg.pulse_one_on_three) begin
			drv[1] = pg[1];
		end
		nxt_st.pin_oe = ~i_cfg.dir_in;
		if (i_cfg.spi_mode) begin
			nxt_st.pin_oe[0] = 1'b0;
			nxt_st.pin_oe[1] = 1'b1;
			drv[1] = i_spi_miso;
		end
		if (i_cfg.irq_on_pin_two) begin
			nxt_st.pin_oe[2] = 1'b1;
			drv[2] = nxt_st.irq_n;
		end
		nxt_st.pin_o = drv;
		nxt_st.pull = i_cfg.pull_up & ~nxt_st.pin_oe;

		// condition bits
		for (int i = 0; i < 4; i++) begin
			rd[i] = i_cfg.dir_in[i] ? filt[i] : st_ff.lvl[i];
		end
		nxt_st.cond = 64'h0000_0000_0000_0000;
		nxt_st.cond[3:0] = rd;
		nxt_st.cond[RB_RES_BUSY] = i_status.resistance_busy;
		nxt_st.cond[RB_TEMP_ERR_N] = i_status.temp_error_n;
		nxt_st.cond[RB_IRQ_PIN] = st_ff.irq_n;
		nxt_st.cond[RB_EEPROM_BUSY] = i_status.eeprom_busy;
		nxt_st.cond[RB_LOWBAT_BUSY] = i_status.low_battery_busy;
		nxt_st.cond[RB_FE_ACTIVE_N] = i_status.frontend_active_n;
		nxt_st.cond[RB_COMB_ERR_N] = i_status.combined_error_flag_n;
		nxt_st.cond[RB_CAP_ERR_N] = i_status.cap_error_flag_n;
		nxt_st.cond[RB_POS] = st_ff.flags.pos;
		nxt_st.cond[RB_NE] = ~st_ff.flags.eq;
		nxt_st.cond[RB_EQ] = st_ff.flags.eq;
		nxt_st.cond[RB_CAR] = st_ff.flags.car;
		nxt_st.cond[RB_CAR_N] = ~st_ff.flags.car;
		nxt_st.cond[RB_OFL] = st_ff.flags.ofl;
		nxt_st.cond[RB_OFL_N] = ~st_ff.flags.ofl;
		nxt_st.cond[RB_PIN_TRIG_N] = ~st_ff.pin_trig;
		nxt_st.cond[RB_LVL_FEEDBACK +: 8] = st_ff.lvl;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st_ff <= '0;
			st_ff.lvl <= LVL_RST;
			st_ff.irq_n <= IRQ_N_RST;
			st_ff.flags <= FLAGS_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_pin = st_ff.pin_o;
	assign o_pin_oe = st_ff.pin_oe;
	assign o_pin_pullup = st_ff.pull;
	assign o_pin_four = st_ff.lvl[WB_PIN_FOUR];
	assign o_pin_five = st_ff.lvl[WB_PIN_FIVE];
	assign o_irq_pin_n = st_ff.irq_n;
	assign o_spi_ssn = st_ff.sync2[0];
	assign o_dsp_start = st_ff.start;
	assign o_trigger_latch = st_ff.latch;
	assign o_strobe = st_ff.strobe;
	assign o_flags = st_ff.flags;
	assign o_cond = st_ff.cond;
endmodule
`default_nettype wire

/* test/dio_fw_model.sv */
/*
 firmware side model: issues one bit set or clear instruction per request.
 assumes requests arrive one cycle apart or more.
*/
`timescale 1ns/100ps
`default_nettype none
module dio_fw_model
	import dio_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_go,
	input wire logic i_set,
	input wire logic [3:0] i_idx,
	output var dio_bit_wr_type o_bit_wr
);
	// ----
	// bit instruction, reserved bit never written
	// ----
	always @(posedge i_clk_sys) begin
		o_bit_wr.valid <= i_go && i_idx != 4'ha;
		o_bit_wr.set <= i_set;
		o_bit_wr.idx <= i_idx;
	end
endmodule
`default_nettype wire

/* test/dio_props.sv */
/*
 port checks of dio_top.
 assumes one clock i_clk_sys and the synchronous reset i_sys_rst.
*/
`timescale 1ns/100ps
`default_nettype none
module dio_props
	import dio_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire dio_bit_wr_type i_bit_wr,
	input wire dio_alu_req_type i_alu,
	input wire dio_status_type i_status,
	input wire logic i_i2c_stop,
	input wire logic o_irq_pin_n,
	input wire logic o_dsp_start,
	input wire dio_strobe_type o_strobe,
	input wire dio_flags_type o_flags,
	input wire logic [63:0] o_cond
);
	logic [15:0] set_hit;
	logic [48:0] add_sum;
	logic sub_car;
	assign set_hit = (i_bit_wr.valid && i_bit_wr.set) ? (16'h1 << i_bit_wr.idx) : 16'h0;
	assign add_sum = {1'b0, i_alu.a} + {1'b0, i_alu.b};
	assign sub_car = i_alu.a >= i_alu.b;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_sys_rst);
	// ----
	// checks
	// ----
	chk_cap_start: assert property (set_hit[8] |=> o_strobe.capacitance_start_pulse)
		else $error("capacitance start missing");
	chk_res_cause: assert property (o_strobe.resistance_start_pulse |-> $past(set_hit[9]))
		else $error("resistance start without write");
	chk_bandgap_pulse: assert property (set_hit[15] |=> o_strobe.bandgap_start_pulse
		##1 (o_strobe.bandgap_start_pulse == $past(set_hit[15])))
		else $error("bandgap pulse wrong");
	chk_lowbat_cause: assert property (o_strobe.low_battery_start_pulse |-> $past(set_hit[14]))
		else $error("low battery start without write");
	chk_erase_strobe: assert property (set_hit[13] |=> o_strobe.eeprom_erase_strobe)
		else $error("erase strobe missing");
	chk_irq_set: assert property (set_hit[11] |=> !o_irq_pin_n)
		else $error("interrupt pin not asserted");
	chk_irq_release: assert property (i_i2c_stop && !set_hit[11] |-> ##[1:3] o_irq_pin_n)
		else $error("interrupt pin not released");
	chk_status_map: assert property (!$past(i_sys_rst) && !$past(i_sys_rst, 2) |->
		o_cond[11] == $past(i_status.cap_error_flag_n))
		else $error("error flag not mapped");
	chk_add_carry: assert property (i_alu.valid && i_alu.op == ALU_ADD |=>
		o_flags.car == $past(add_sum[48]))
		else $error("add carry wrong");
	chk_sub_carry: assert property (i_alu.valid && i_alu.op == ALU_SUB |=>
		o_flags.car == $past(sub_car))
		else $error("sub carry wrong");
	chk_flag_cond: assert property (!$past(i_sys_rst) && !$past(i_sys_rst, 2) |->
		o_cond[44] == $past(o_flags.car) && o_cond[45] != $past(o_flags.car))
		else $error("carry condition bits wrong");
	chk_start_pulse: assert property (o_dsp_start |=> !o_dsp_start)
		else $error("start pulse too long");
endmodule
bind dio_top dio_props u_props (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
	.i_bit_wr(i_bit_wr), .i_alu(i_alu), .i_status(i_status), .i_i2c_stop(i_i2c_stop),
	.o_irq_pin_n(o_irq_pin_n), .o_dsp_start(o_dsp_start), .o_strobe(o_strobe),
	.o_flags(o_flags), .o_cond(o_cond));
`default_nettype wire

/* test/test_dio_top.sv */
/*
 self-checking bench of dio_top with the firmware model on the bit port.
 assumes the checker is bound to the design.
*/
`timescale 1ns/100ps
`default_nettype none
module test_dio_top;
	import dio_pkg::*;
	logic i_clk_sys, i_sys_rst, i_dsp_stop, i_i2c_stop, fw_go, fw_set, spi_miso;
	logic [3:0] fw_idx, ext_pin, i_pin, o_pin, o_pin_oe, o_pin_pullup, o_trigger_latch;
	logic [1:0] i_pulse_gen;
	logic o_pin_four, o_pin_five, o_irq_pin_n, o_spi_ssn, o_dsp_start;
	dio_bit_wr_type bit_wr;
	dio_alu_req_type i_alu;
	dio_status_type i_status;
	dio_cfg_type i_cfg;
	dio_strobe_type o_strobe;
	dio_flags_type o_flags;
	logic [63:0] o_cond;
	int err_total = 0;
	int compares = 0;
	assign i_pin = (o_pin_oe & o_pin) | (~o_pin_oe & ext_pin);
	dio_fw_model fw (.i_clk_sys(i_clk_sys), .i_go(fw_go), .i_set(fw_set), .i_idx(fw_idx),
		.o_bit_wr(bit_wr));
	dio_top #(.p_debounce_cyc(22'h8)) dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
		.i_dsp_stop(i_dsp_stop), .i_bit_wr(bit_wr), .i_alu(i_alu), .i_status(i_status),
		.i_cfg(i_cfg), .i_pulse_gen(i_pulse_gen), .i_spi_miso(spi_miso), .i_i2c_stop(i_i2c_stop),
		.i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe), .o_pin_pullup(o_pin_pullup),
		.o_pin_four(o_pin_four), .o_pin_five(o_pin_five), .o_irq_pin_n(o_irq_pin_n),
		.o_spi_ssn(o_spi_ssn), .o_dsp_start(o_dsp_start), .o_trigger_latch(o_trigger_latch),
		.o_strobe(o_strobe), .o_flags(o_flags), .o_cond(o_cond));
	// ----
	// shared tasks
	// ----
	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_verdict;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] idx, input logic set);
		fw_idx = idx;
		fw_set = set;
		fw_go = 1'b1;
		@(negedge i_clk_sys);
		fw_go = 1'b0;
		@(negedge i_clk_sys);
	endtask
	task automatic alu(input dio_alu_op_type op, input logic [47:0] a, b, r,
		input logic [1:0] oc, input logic [3:0] f);
		i_alu = '{1'b1, op, a, b, r, oc[1], oc[0]};
		@(negedge i_clk_sys);
		i_alu.valid = 1'b0;
		check("flags", o_flags, f);
		@(negedge i_clk_sys);
		check("cond", o_cond[47:41], {~f[3], f[3], ~f[2], f[2], f[1], ~f[1], f[0]});
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_strobes;
		logic [3:0] ids [6] = '{4'hf, 4'he, 4'hd, 4'hc, 4'h9, 4'h8};
		check("irq_rst", o_irq_pin_n, 1'b1);
		for (int k = 0; k < 6; k++) begin
			wr(ids[k], 1'b1);
			check("strobe", o_strobe, 8'h80 >> k);
			@(negedge i_clk_sys);
			check("strobe_end", o_strobe, 8'h00);
		end
		wr(4'h8, 1'b0);
		check("strobe_clr", o_strobe, 8'h00);
	endtask
	task automatic t_levels;
		for (int k = 0; k < 4; k++) begin
			wr(4'(k + 4), 1'b1);
			check("lvl", {o_strobe[1:0], o_pin_five, o_pin_four}, (4'h2 << k) - 4'h1);
		end
		@(negedge i_clk_sys);
		check("feedback", o_cond[63:56], 8'hf0);
		for (int k = 0; k < 4; k++) begin
			wr(4'(k + 4), 1'b0);
			check("lvl_clr", {o_strobe[1:0], o_pin_five, o_pin_four}, 4'(4'he << k));
		end
	endtask
	task automatic t_status;
		logic [6:0] pats [2] = '{7'h56, 7'h29};
		for (int k = 0; k < 2; k++) begin
			i_status = pats[k];
			repeat (2) @(negedge i_clk_sys);
			check("status", {o_cond[11:7], o_cond[5:4]}, pats[k]);
		end
	endtask
	task automatic t_irq;
		wr(4'hb, 1'b1);
		check("irq_set", o_irq_pin_n, 1'b0);
		repeat (3) @(negedge i_clk_sys);
		check("irq_cond", {o_irq_pin_n, o_cond[6]}, 2'b00);
		i_i2c_stop = 1'b1;
		@(negedge i_clk_sys);
		i_i2c_stop = 1'b0;
		repeat (3) @(negedge i_clk_sys);
		check("irq_rel", o_irq_pin_n, 1'b1);
	endtask
	task automatic t_pins;
		i_cfg.dir_in = 4'h1;
		i_cfg.pull_up = 4'h1;
		wr(4'h2, 1'b1);
		repeat (2) @(negedge i_clk_sys);
		check("pins", {o_pin_oe, o_pin_pullup, o_pin[3:2]}, 10'h385);
		i_cfg.pulse_one_on_three = 1'b1;
		i_cfg.pulse_gen_on = 2'b10;
		for (int k = 0; k < 2; k++) begin
			i_pulse_gen = 2'(~k << 1);
			repeat (3) @(negedge i_clk_sys);
			check("pulse", o_pin[3], k == 0);
		end
	endtask
	task automatic t_trig;
		int n = 0;
		i_cfg.latch_mask = 4'h1;
		i_cfg.debounce_en = 4'h1;
		ext_pin[0] = 1'b1;
		while (o_dsp_start !== 1'b1 && n < 12) begin
			@(negedge i_clk_sys);
			n++;
		end
		check("start", o_dsp_start, 1'b1);
		check("pin_read", {o_cond[2], o_cond[0]}, 2'b11);
		repeat (3) @(negedge i_clk_sys);
		check("trig_n", o_cond[53], 1'b0);
		wr(4'h0, 1'b1);
		wr(4'h0, 1'b0);
		check("latch_clr", o_trigger_latch[0], 1'b0);
		ext_pin[0] = 1'b0;
		repeat (2) @(negedge i_clk_sys);
		ext_pin[0] = 1'b1;
		repeat (5) @(negedge i_clk_sys);
		check("latch_held", o_trigger_latch[0], 1'b0);
		repeat (12) @(negedge i_clk_sys);
		check("latch_late", o_trigger_latch[0], 1'b1);
		i_dsp_stop = 1'b1;
		@(negedge i_clk_sys);
		i_dsp_stop = 1'b0;
		repeat (2) @(negedge i_clk_sys);
		check("trig_stop", o_cond[53], 1'b1);
	endtask
	task automatic t_spi;
		spi_miso = 1'b1;
		i_cfg.spi_mode = 1'b1;
		i_cfg.irq_on_pin_two = 1'b1;
		ext_pin[0] = 1'b0;
		wr(4'hb, 1'b1);
		check("spi_pins", {o_pin_oe[2:0], o_pin[2:1], o_spi_ssn}, 6'h32);
		ext_pin[0] = 1'b1;
		repeat (4) @(negedge i_clk_sys);
		check("ssn_rel", {o_irq_pin_n, o_spi_ssn, o_pin[2]}, 3'h7);
	endtask
	// ----
	// clock, run, watchdog
	// ----
	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		err_total++;
		give_verdict();
	end
	initial begin
		{i_dsp_stop, i_i2c_stop, fw_go, fw_set, fw_idx, ext_pin, i_pulse_gen, spi_miso} = '0;
		i_alu = '0;
		i_status = '0;
		i_cfg = '0;
		i_sys_rst = 1'b1;
		repeat (8) @(negedge i_clk_sys);
		i_sys_rst = 1'b0;
		@(negedge i_clk_sys);
		t_strobes();
		t_levels();
		t_status();
		t_irq();
		alu(ALU_ADD, 48'h7fffffffffff, 48'h1, 48'h0, 2'b00, 4'h8);
		alu(ALU_ADD, 48'hffffffffffff, 48'h1, 48'h0, 2'b00, 4'h7);
		alu(ALU_SUB, 48'h5, 48'h7, 48'h0, 2'b00, 4'h0);
		alu(ALU_SUB, 48'h7, 48'h7, 48'h0, 2'b00, 4'h7);
		alu(ALU_MOVE, 48'h0, 48'h0, 48'hffffffffffff, 2'b00, 4'h4);
		alu(ALU_MULDIV, 48'h0, 48'h0, 48'h0, 2'b10, 4'hb);
		t_pins();
		t_trig();
		t_spi();
		give_verdict();
	end
endmodule
`default_nettype wire
